// ### rcpeq_top.sv
// Purpose: parameter range checks, error queue and status summaries
// Assumes: parser presents one decoded item per cycle
// Notes:   results register one cycle after the strobe
`timescale 1ns/1ns
`include "rcpeq_regs.svh"
module rcpeq_top
    import rcpeq_pkg::*;
#(
    parameter int QUEUE_DEPTH = 8
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        SRST_IN,
    input  wire logic        CLEAR_STATUS_IN,
    input  wire logic        ERR_QUERY_IN,
    input  wire logic        PARAM_VALID_IN,
    input  wire logic [3:0]  PARAM_KIND_IN,
    input  wire logic [31:0] PARAM_VALUE_IN,
    input  wire logic [1:0]  PARAM_UNIT_IN,
    input  wire logic        PARAM_UNIT_GIVEN_IN,
    input  wire logic        PARAM_IS_SUFFIX_IN,
    input  wire logic        BOOL_IS_WORD_IN,
    input  wire logic        BOOL_WORD_ON_IN,
    input  wire logic        SYNTAX_ERR_IN,
    input  wire logic        TRIGGER_MID_MSG_IN,
    input  wire logic        NUMERIC_BAD_IN,
    input  wire logic        EXP_VALID_IN,
    input  wire logic [15:0] EXP_MAG_IN,
    input  wire logic        STRING_BAD_IN,
    input  wire logic        DEV_ERR_VALID_IN,
    input  wire logic [14:0] DEV_ERR_CODE_IN,
    input  wire logic        EVENT_MASK_WE_IN,
    input  wire logic [7:0]  EVENT_MASK_IN,
    input  wire logic        COND_MASK_WE_IN,
    input  wire logic [15:0] COND_MASK_IN,
    input  wire logic [15:0] COND_BITS_IN,
    input  wire logic        ESR_READ_IN,
    output logic             EXECUTE_OUT,
    output logic [31:0]      VALUE_OUT,
    output logic             BOOL_STATE_OUT,
    output logic [15:0]      ERR_CODE_OUT,
    output logic             ERR_CODE_VALID_OUT,
    output logic             QUEUE_EMPTY_OUT,
    output logic             QUEUE_FULL_OUT,
    output logic [7:0]       EVENT_STATUS_OUT,
    output logic [7:0]       EVENT_MASK_OUT,
    output logic             EVENT_SUMMARY_BIT_OUT,
    output logic [15:0]      COND_MASK_OUT,
    output logic             COND_SUMMARY_OUT
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic in_range(input logic [31:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (v >= {16'h0000, lo}) && (v <= {16'h0000, hi});
    endfunction
    function automatic logic in_class(input logic [15:0] c,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (c >= lo) && (c <= hi);
    endfunction
    // ----------------------------------------
    // parameter range decode
    // ----------------------------------------
    wire [31:0] delay_ms =
        (PARAM_UNIT_IN == RCPEQ_U_MS)  ? PARAM_VALUE_IN :
        (PARAM_UNIT_IN == RCPEQ_U_MIN) ?
            32'(PARAM_VALUE_IN * `RCPEQ_MS_PER_S * 32'h0000003C) :
            32'(PARAM_VALUE_IN * `RCPEQ_MS_PER_S);
    // no unit means seconds
    wire [31:0] delay_eff = PARAM_UNIT_GIVEN_IN ? delay_ms
                          : 32'(PARAM_VALUE_IN * `RCPEQ_MS_PER_S);
    wire chan_ok  = in_range(PARAM_VALUE_IN, `RCPEQ_CHAN_MIN,
                             `RCPEQ_CHAN_MAX);
    wire node_ok  = in_range(PARAM_VALUE_IN, `RCPEQ_NODE_MIN,
                             `RCPEQ_NODE_MAX);
    wire setup_ok = in_range(PARAM_VALUE_IN, `RCPEQ_SETUP_MIN,
                             `RCPEQ_SETUP_MAX);
    wire rep_ok   = in_range(PARAM_VALUE_IN, `RCPEQ_REP_MIN,
                             `RCPEQ_REP_MAX);
    wire seq_ok   = in_range(PARAM_VALUE_IN, `RCPEQ_SEQ_MIN,
                             `RCPEQ_SEQ_MAX);
    wire step_ok  = in_range(PARAM_VALUE_IN, `RCPEQ_STEP_MIN,
                             `RCPEQ_STEP_MAX);
    // wide product overflow guarded by a coarse limit on the raw value
    wire delay_ok = (PARAM_VALUE_IN <= `RCPEQ_DELAY_MAX_MS) &&
                    (delay_eff <= `RCPEQ_DELAY_MAX_MS);
    wire bool_ok  = BOOL_IS_WORD_IN || (PARAM_VALUE_IN <= 32'h00000001);
    wire bool_val = BOOL_IS_WORD_IN ? BOOL_WORD_ON_IN
                                    : PARAM_VALUE_IN[0];
    logic value_ok;
    always_comb begin
        value_ok = 1'b0;
        case (PARAM_KIND_IN)
            RCPEQ_P_CHAN:  value_ok = chan_ok;
            RCPEQ_P_NODE:  value_ok = node_ok;
            RCPEQ_P_SETUP: value_ok = setup_ok;
            RCPEQ_P_REP:   value_ok = rep_ok;
            RCPEQ_P_SEQ:   value_ok = seq_ok;
            RCPEQ_P_STEP:  value_ok = step_ok;
            RCPEQ_P_DELAY: value_ok = delay_ok;
            RCPEQ_P_BOOL:  value_ok = bool_ok;
            default:       value_ok = 1'b0;
        endcase
    end
    wire exp_bad = EXP_VALID_IN && (EXP_MAG_IN > `RCPEQ_EXP_MAX);
    wire any_fault = SYNTAX_ERR_IN || TRIGGER_MID_MSG_IN ||
                     NUMERIC_BAD_IN || exp_bad || STRING_BAD_IN;
    wire range_bad = PARAM_VALID_IN && !any_fault && !value_ok;
    // ----------------------------------------
    // error selection, most specific first
    // ----------------------------------------
    wire [15:0] parse_code =
        TRIGGER_MID_MSG_IN ? `RCPEQ_ERR_GET :
        exp_bad            ? `RCPEQ_ERR_EXPONENT :
        NUMERIC_BAD_IN     ? `RCPEQ_ERR_NUMERIC :
        STRING_BAD_IN      ? `RCPEQ_ERR_STRING :
                             `RCPEQ_ERR_CMD;
    wire suffix_bad = range_bad && PARAM_IS_SUFFIX_IN;
    wire [15:0] check_code =
        any_fault  ? parse_code :
        suffix_bad ? `RCPEQ_ERR_SUFFIX :
                     `RCPEQ_ERR_RANGE;
    wire check_err = (PARAM_VALID_IN && any_fault) || range_bad ||
                     (!PARAM_VALID_IN && any_fault);
    // instrument-specific codes forced positive
    wire [15:0] dev_code = {1'b0, DEV_ERR_CODE_IN};
    wire        push     = check_err || DEV_ERR_VALID_IN;
    wire [15:0] push_code = check_err ? check_code : dev_code;
    // ----------------------------------------
    // error queue
    // ----------------------------------------
    wire [15:0] head;
    wire        q_empty;
    wire        q_full;
    // a query on the last entry drains it, which empties the queue
    rcpeq_fifo #(
        .DEPTH     (QUEUE_DEPTH),
        .WIDTH     (16)
    ) u_queue (
        .clk_in    (CLK_SYS_IN),
        .srst_in   (SRST_IN),
        .clear_in  (CLEAR_STATUS_IN),
        .push_in   (push && !CLEAR_STATUS_IN),
        .code_in   (push_code),
        .pop_in    (ERR_QUERY_IN),
        .head_out  (head),
        .empty_out (q_empty),
        .full_out  (q_full)
    );
    // ----------------------------------------
    // event status, set wins over read clear
    // ----------------------------------------
    wire set_cmd = push && !CLEAR_STATUS_IN &&
                   in_class(push_code, `RCPEQ_CMD_LO, `RCPEQ_CMD_HI);
    wire set_exe = push && !CLEAR_STATUS_IN &&
                   in_class(push_code, `RCPEQ_EXE_LO, `RCPEQ_EXE_HI);
    logic [7:0] esr;
    wire  [7:0] esr_kept = (ESR_READ_IN || CLEAR_STATUS_IN) ? 8'h00 : esr;
    wire  [7:0] next_esr = esr_kept |
                           (8'(set_cmd) << `RCPEQ_ESR_CMD_BIT) |
                           (8'(set_exe) << `RCPEQ_ESR_EXE_BIT);
    logic [7:0]  ev_mask;
    logic [15:0] cd_mask;
    wire  [7:0]  next_ev_mask = EVENT_MASK_WE_IN ? EVENT_MASK_IN : ev_mask;
    wire  [15:0] next_cd_mask = COND_MASK_WE_IN ? COND_MASK_IN : cd_mask;
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            esr     <= `RCPEQ_ESR_RESET;
            ev_mask <= `RCPEQ_MASK8_RESET;
            cd_mask <= `RCPEQ_MASK16_RESET;
        end else begin
            esr     <= next_esr;
            ev_mask <= next_ev_mask;
            cd_mask <= next_cd_mask;
        end
    end
    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            EXECUTE_OUT           <= 1'b0;
            VALUE_OUT             <= 32'h00000000;
            BOOL_STATE_OUT        <= 1'b0;
            ERR_CODE_OUT          <= `RCPEQ_ERR_NONE;
            ERR_CODE_VALID_OUT    <= 1'b0;
            QUEUE_EMPTY_OUT       <= 1'b1;
            QUEUE_FULL_OUT        <= 1'b0;
            EVENT_STATUS_OUT      <= `RCPEQ_ESR_RESET;
            EVENT_MASK_OUT        <= `RCPEQ_MASK8_RESET;
            EVENT_SUMMARY_BIT_OUT <= 1'b0;
            COND_MASK_OUT         <= `RCPEQ_MASK16_RESET;
            COND_SUMMARY_OUT      <= 1'b0;
        end else begin
            EXECUTE_OUT <= PARAM_VALID_IN && !check_err;
            VALUE_OUT   <= (PARAM_KIND_IN == RCPEQ_P_DELAY) ? delay_eff
                                                            : PARAM_VALUE_IN;
            if (PARAM_VALID_IN && !check_err &&
                PARAM_KIND_IN == RCPEQ_P_BOOL) begin
                BOOL_STATE_OUT <= bool_val;
            end
            if (ERR_QUERY_IN) begin
                ERR_CODE_OUT <= q_empty ? `RCPEQ_ERR_NONE : head;
            end
            ERR_CODE_VALID_OUT    <= ERR_QUERY_IN;
            QUEUE_EMPTY_OUT       <= q_empty;
            QUEUE_FULL_OUT        <= q_full;
            EVENT_STATUS_OUT      <= next_esr;
            EVENT_MASK_OUT        <= next_ev_mask;
            EVENT_SUMMARY_BIT_OUT <= |(next_esr & next_ev_mask);
            COND_MASK_OUT         <= next_cd_mask;
            COND_SUMMARY_OUT      <= |(COND_BITS_IN & next_cd_mask);
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    chan_reject_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        PARAM_VALID_IN && PARAM_KIND_IN == RCPEQ_P_CHAN &&
        PARAM_VALUE_IN > 32'h00000032 |=> !EXECUTE_OUT)
        else $error("channel above 50 executed");
    node_reject_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        PARAM_VALID_IN && PARAM_KIND_IN == RCPEQ_P_NODE &&
        PARAM_VALUE_IN == 32'h00000000 |=> !EXECUTE_OUT)
        else $error("node id zero executed");
    rep_accept_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        PARAM_VALID_IN && !any_fault && PARAM_KIND_IN == RCPEQ_P_REP &&
        PARAM_VALUE_IN == 32'h0000270F |=> EXECUTE_OUT)
        else $error("repeat count 9999 refused");
    step_reject_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        PARAM_VALID_IN && PARAM_KIND_IN == RCPEQ_P_STEP &&
        PARAM_VALUE_IN == 32'h00000064 |=> !EXECUTE_OUT)
        else $error("step 100 executed");
    cmd_bit_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        set_cmd && !ESR_READ_IN |=> EVENT_STATUS_OUT[5])
        else $error("command error bit not set");
    exe_bit_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        set_exe |=> EVENT_STATUS_OUT[4])
        else $error("execution error bit not set");
    empty_zero_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        ERR_QUERY_IN && q_empty |=> ERR_CODE_OUT == 16'h0000)
        else $error("empty query not zero");
    clear_empty_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        CLEAR_STATUS_IN |=> q_empty ##1 QUEUE_EMPTY_OUT)
        else $error("clear left queue filled");
    summary_mask_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        EVENT_MASK_OUT == 8'h00 |-> !EVENT_SUMMARY_BIT_OUT)
        else $error("summary set with empty mask");
    suffix_code_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        suffix_bad && !CLEAR_STATUS_IN |=> EVENT_STATUS_OUT[5] &&
        !EXECUTE_OUT)
        else $error("bad suffix not logged as command error");
    over_full_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        q_full && push && !CLEAR_STATUS_IN && !ERR_QUERY_IN |=> q_full)
        else $error("overflow push changed queue fill");
    exec_idle_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        !PARAM_VALID_IN |=> !EXECUTE_OUT)
        else $error("execute without parameter");
    delay_limit_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        PARAM_VALID_IN && PARAM_KIND_IN == RCPEQ_P_DELAY &&
        delay_eff > `RCPEQ_DELAY_MAX_MS |=> !EXECUTE_OUT)
        else $error("delay above sixty seconds executed");
    empty_flag_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (SRST_IN)
        q_empty |=> QUEUE_EMPTY_OUT)
        else $error("empty flag output lost");
endmodule

// ### rcpeq_regs.svh
// Purpose: constants for the remote command parameter checker
// Assumes: one system clock, synchronous reset
// Notes:   codes are 16-bit two's complement
`ifndef RCPEQ_REGS_SVH
`define RCPEQ_REGS_SVH
// ----------------------------------------
// error codes
// ----------------------------------------
`define RCPEQ_ERR_NONE      16'h0000
`define RCPEQ_ERR_CMD       16'hFF9C
`define RCPEQ_ERR_GET       16'hFF97
`define RCPEQ_ERR_SUFFIX    16'hFF8E
`define RCPEQ_ERR_NUMERIC   16'hFF88
`define RCPEQ_ERR_EXPONENT  16'hFF85
`define RCPEQ_ERR_STRING    16'hFF69
`define RCPEQ_ERR_RANGE     16'hFF22
`define RCPEQ_ERR_OVERFLOW  16'hFEA2
`define RCPEQ_CMD_LO        16'hFF39
`define RCPEQ_CMD_HI        16'hFF9C
`define RCPEQ_EXE_LO        16'hFED5
`define RCPEQ_EXE_HI        16'hFF38
// ----------------------------------------
// event status bit positions and reset values
// ----------------------------------------
`define RCPEQ_ESR_EXE_BIT   4
`define RCPEQ_ESR_CMD_BIT   5
`define RCPEQ_ESR_RESET     8'h00
`define RCPEQ_MASK8_RESET   8'h00
`define RCPEQ_MASK16_RESET  16'h0000
// ----------------------------------------
// parameter ranges
// ----------------------------------------
`define RCPEQ_CHAN_MIN      16'h0002
`define RCPEQ_CHAN_MAX      16'h0032
`define RCPEQ_NODE_MIN      16'h0001
`define RCPEQ_NODE_MAX      16'h001E
`define RCPEQ_SETUP_MIN     16'h0001
`define RCPEQ_SETUP_MAX     16'h000A
`define RCPEQ_REP_MIN       16'h0001
`define RCPEQ_REP_MAX       16'h270F
`define RCPEQ_SEQ_MIN       16'h0001
`define RCPEQ_SEQ_MAX       16'h000A
`define RCPEQ_STEP_MIN      16'h0001
`define RCPEQ_STEP_MAX      16'h0063
`define RCPEQ_EXP_MAX       16'h7D00
// delay held in milliseconds, sixty seconds
`define RCPEQ_DELAY_MAX_MS  32'h0000EA60
`define RCPEQ_MS_PER_S      32'h000003E8
`endif

// ### rcpeq_pkg.sv
// Purpose: types for the remote command parameter checker
// Assumes: nothing
// Notes:   kinds of checked parameter
package rcpeq_pkg;
    typedef enum logic [3:0] {
        RCPEQ_P_CHAN  = 4'h0,
        RCPEQ_P_NODE  = 4'h1,
        RCPEQ_P_SETUP = 4'h2,
        RCPEQ_P_REP   = 4'h3,
        RCPEQ_P_SEQ   = 4'h4,
        RCPEQ_P_STEP  = 4'h5,
        RCPEQ_P_DELAY = 4'h6,
        RCPEQ_P_BOOL  = 4'h7
    } rcpeq_param_t;
    typedef enum logic [1:0] {
        RCPEQ_U_S   = 2'h0,
        RCPEQ_U_MS  = 2'h1,
        RCPEQ_U_MIN = 2'h2
    } rcpeq_unit_t;
endpackage

// ### rcpeq_fifo.sv
// Purpose: error queue, oldest first, overflow replacement
// Assumes: push and pop from same clock
// Notes:   depth is a build parameter
`timescale 1ns/1ns
module rcpeq_fifo #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             clear_in,
    input  wire logic             push_in,
    input  wire logic [WIDTH-1:0] code_in,
    input  wire logic             pop_in,
    output logic      [WIDTH-1:0] head_out,
    output logic                  empty_out,
    output logic                  full_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // overflow and no-error codes are sixteen bits wide
    if (DEPTH < 2 || WIDTH != 16) begin : g_size_check
        $error("queue needs depth two or more and width sixteen");
    end
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    wr_ptr;
    logic [AW:0]      count;
    wire              do_pop  = pop_in && (count != '0);
    wire              is_full = (count == (AW+1)'(DEPTH));
    wire  [AW-1:0]    last_ptr = (wr_ptr == '0) ? AW'(DEPTH - 1)
                                                : wr_ptr - 1'b1;
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction
    always_ff @(posedge clk_in) begin
        if (srst_in || clear_in) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end else begin
            if (push_in && is_full && !do_pop) begin
                mem[last_ptr] <= `RCPEQ_ERR_OVERFLOW;
            end else if (push_in) begin
                mem[wr_ptr] <= code_in;
                wr_ptr      <= bump(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push_in && !(is_full && !do_pop) && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !push_in) begin
                count <= count - 1'b1;
            end
        end
    end
    assign head_out  = (count == '0) ? `RCPEQ_ERR_NONE : mem[rd_ptr];
    assign empty_out = (count == '0);
    assign full_out  = is_full;
endmodule

// ### rcpeq_host.sv
// Purpose: remote host model presenting decoded parameter items
// Assumes: items change at the falling clock edge, one cycle each
// Notes:   out-of-range items go out only when a test sends them
`timescale 1ns/1ns
module rcpeq_host (
    input  wire logic        clk_in,
    output logic             valid_out,
    output logic [3:0]       kind_out,
    output logic [31:0]      value_out,
    output logic [1:0]       unit_out,
    output logic             given_out,
    output logic             suffix_out,
    output logic             word_out,
    output logic             on_out
);
    int n_bad;
    initial begin
        n_bad = 0;
        {valid_out, kind_out, value_out, unit_out} = '0;
        {given_out, suffix_out, word_out, on_out} = '0;
    end
    // ----------------------------------------
    // ranges a well-behaved host keeps
    // ----------------------------------------
    function automatic bit legal(input logic [3:0] k, input logic [31:0] v);
        case (k)
            4'h0: legal = v >= 32'h2 && v <= 32'h32;
            4'h1: legal = v >= 32'h1 && v <= 32'h1E;
            4'h2: legal = v >= 32'h1 && v <= 32'hA;
            4'h3: legal = v >= 32'h1 && v <= 32'h270F;
            4'h4: legal = v >= 32'h1 && v <= 32'hA;
            4'h5: legal = v >= 32'h1 && v <= 32'h63;
            default: legal = 1'b1;
        endcase
    endfunction
    task automatic send(input logic [3:0] k, input logic [31:0] v,
                        input logic [1:0] u, input logic g, s, w, o);
        @(negedge clk_in);
        if (!legal(k, v))
            n_bad++;
        {valid_out, kind_out, value_out, unit_out} = {1'h1, k, v, u};
        {given_out, suffix_out, word_out, on_out} = {g, s, w, o};
        @(negedge clk_in);
        valid_out = 1'h0;
        // released value and kind lines show the inverse so a stale value never passes
        value_out = ~v;
        kind_out = ~k;
    endtask
endmodule

// ### rcpeq_bench.sv
// Purpose: self-checking bench for the parameter checker and queue
// Assumes: inputs change at the falling edge, queue depth 4
// Notes:   every query also reads and clears event status
`timescale 1ns/1ns
`include "rcpeq_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    (got), (exp)); end end
module remote_cmd_param_check_error_queue_bench
    import rcpeq_pkg::*;
;
    typedef struct packed {
        logic [3:0]  kind;
        logic [31:0] value;
        logic [1:0]  unit;
        logic        given;
        logic        suffix;
        logic [15:0] code;
    } rcpeq_row_t;
    logic        clk, srst, clr, qry, dev_v, emw, cmw;
    logic [14:0] dev_c;
    logic [7:0]  em;
    logic [15:0] cm, cb, emag;
    logic [4:0]  flt;
    logic        p_v, p_g, p_s, p_w, p_o;
    logic [3:0]  p_k;
    logic [31:0] p_val;
    logic [1:0]  p_u;
    wire         exec, bst, evld, qe, qf, event_summary_bit, csum;
    wire  [31:0] vout;
    wire  [15:0] ecode, cmo;
    wire  [7:0]  esr, emo;
    int          n_fail, checks;
    rcpeq_row_t  rows [0:17] = '{
        '{4'h0, 32'h1, 2'h0, 1'h0, 1'h1, `RCPEQ_ERR_SUFFIX},
        '{4'h0, 32'h32, 2'h0, 1'h0, 1'h1, 16'h0},
        '{4'h0, 32'h33, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h1, 32'h0, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h1, 32'h1E, 2'h0, 1'h0, 1'h0, 16'h0},
        '{4'h1, 32'h1F, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h2, 32'hB, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h2, 32'hA, 2'h0, 1'h0, 1'h0, 16'h0},
        '{4'h3, 32'h270F, 2'h0, 1'h0, 1'h0, 16'h0},
        '{4'h3, 32'h2710, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h4, 32'hB, 2'h0, 1'h0, 1'h1, `RCPEQ_ERR_SUFFIX},
        '{4'h5, 32'h63, 2'h0, 1'h0, 1'h1, 16'h0},
        '{4'h6, 32'h3C, 2'h0, 1'h0, 1'h0, 16'h0},
        '{4'h6, 32'h3D, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h6, 32'h1, 2'h2, 1'h1, 1'h0, 16'h0},
        '{4'h7, 32'h2, 2'h0, 1'h0, 1'h0, `RCPEQ_ERR_RANGE},
        '{4'h5, 32'h64, 2'h0, 1'h0, 1'h1, `RCPEQ_ERR_SUFFIX},
        '{4'h6, 32'hEA60, 2'h1, 1'h1, 1'h0, 16'h0}};
    logic [15:0] fcode [0:4] = '{`RCPEQ_ERR_CMD, `RCPEQ_ERR_GET,
        `RCPEQ_ERR_NUMERIC, `RCPEQ_ERR_STRING, `RCPEQ_ERR_EXPONENT};
    rcpeq_host host (.clk_in(clk), .valid_out(p_v), .kind_out(p_k),
        .value_out(p_val), .unit_out(p_u), .given_out(p_g),
        .suffix_out(p_s), .word_out(p_w), .on_out(p_o));
    rcpeq_top #(.QUEUE_DEPTH(4)) dut (.CLK_SYS_IN(clk), .SRST_IN(srst),
        .CLEAR_STATUS_IN(clr), .ERR_QUERY_IN(qry), .PARAM_VALID_IN(p_v),
        .PARAM_KIND_IN(p_k), .PARAM_VALUE_IN(p_val), .PARAM_UNIT_IN(p_u),
        .PARAM_UNIT_GIVEN_IN(p_g), .PARAM_IS_SUFFIX_IN(p_s),
        .BOOL_IS_WORD_IN(p_w), .BOOL_WORD_ON_IN(p_o),
        .SYNTAX_ERR_IN(flt[0]), .TRIGGER_MID_MSG_IN(flt[1]),
        .NUMERIC_BAD_IN(flt[2]), .EXP_VALID_IN(flt[4]), .EXP_MAG_IN(emag),
        .STRING_BAD_IN(flt[3]), .DEV_ERR_VALID_IN(dev_v),
        .DEV_ERR_CODE_IN(dev_c), .EVENT_MASK_WE_IN(emw),
        .EVENT_MASK_IN(em), .COND_MASK_WE_IN(cmw), .COND_MASK_IN(cm),
        .COND_BITS_IN(cb), .ESR_READ_IN(qry), .EXECUTE_OUT(exec),
        .VALUE_OUT(vout), .BOOL_STATE_OUT(bst), .ERR_CODE_OUT(ecode),
        .ERR_CODE_VALID_OUT(evld), .QUEUE_EMPTY_OUT(qe),
        .QUEUE_FULL_OUT(qf), .EVENT_STATUS_OUT(esr), .EVENT_MASK_OUT(emo),
        .EVENT_SUMMARY_BIT_OUT(event_summary_bit), .COND_MASK_OUT(cmo),
        .COND_SUMMARY_OUT(csum));
    always #20 clk = ~clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic query(input logic [15:0] code);
        @(negedge clk);
        qry = 1'h1;
        @(negedge clk);
        qry = 1'h0;
        `CHK({evld, ecode}, {1'h1, code})
    endtask
    task automatic fault(input logic [4:0] f);
        @(negedge clk);
        flt = f;
        @(negedge clk);
        flt = 5'h0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clk, clr, qry, dev_v, emw, cmw, dev_c, em, cm, cb, flt} = '0;
        {n_fail, checks} = '0;
        emag = 16'h7D01;
        srst = 1'h1;
        repeat (2) @(negedge clk);
        srst = 1'h0;
        `CHK({qe, esr, ecode}, {1'h1, 8'h0, 16'h0})
        `CHK({emo, cmo}, 24'h0)
        foreach (rows[i]) begin
            host.send(rows[i].kind, rows[i].value, rows[i].unit,
                      rows[i].given, rows[i].suffix, 1'h0, 1'h0);
            `CHK(exec, rows[i].code === 16'h0)
            if (rows[i].code === 16'h0) begin
                `CHK(vout, rows[i].kind == 4'h6 ? 32'hEA60 : rows[i].value)
            end else begin
                `CHK(esr, rows[i].code == `RCPEQ_ERR_SUFFIX ? 8'h20 : 8'h10)
                query(rows[i].code);
            end
        end
        for (int b = 0; b < 4; b++) begin
            host.send(4'h7, {31'h0, b[1] ^ b[0]}, 2'h0, 1'h0, 1'h0,
                      b[1], b[0]);
            `CHK(bst, b[0])
        end
        for (int j = 0; j < 5; j++) begin
            fault(5'h1 << j);
            `CHK(esr, 8'h20)
            query(fcode[j]);
        end
        emag = 16'h7D00;
        fault(5'h10);
        @(negedge clk);
        `CHK({esr, qe}, {8'h0, 1'h1})
        {emw, em, cmw, cm, cb} = {1'h1, 8'h20, 1'h1, 16'h0100, 16'h0100};
        fault(5'h1);
        emw = 1'h0;
        cmw = 1'h0;
        `CHK({event_summary_bit, emo, csum, cmo}, {1'h1, 8'h20, 1'h1, 16'h0100})
        {emw, em, cb} = {1'h1, 8'h10, 16'h0200};
        @(negedge clk);
        emw = 1'h0;
        @(negedge clk);
        `CHK({event_summary_bit, csum}, 2'h0)
        query(`RCPEQ_ERR_CMD);
        for (int j = 1; j < 6; j++) begin
            @(negedge clk);
            {dev_v, dev_c} = {1'h1, 15'(j)};
        end
        @(negedge clk);
        dev_v = 1'h0;
        @(negedge clk);
        `CHK({qf, esr}, {1'h1, 8'h0})
        for (int j = 1; j < 4; j++)
            query(16'(j));
        query(`RCPEQ_ERR_OVERFLOW);
        @(negedge clk);
        `CHK(qe, 1'h1)
        query(`RCPEQ_ERR_NONE);
        {dev_v, dev_c} = {1'h1, 15'h7};
        @(negedge clk);
        {dev_v, dev_c, clr} = {1'h1, 15'h8, 1'h1};
        @(negedge clk);
        {dev_v, clr} = 2'h0;
        @(negedge clk);
        `CHK(qe, 1'h1)
        query(`RCPEQ_ERR_NONE);
        `CHK(host.n_bad, 8)
        end_of_test();
    end
endmodule
